// [pkg/dcfrm_pkg.sv]
// Shared constants and pin bundles for the replay FIFO with mailboxes
`default_nettype none
package dcfrm_pkg;
  localparam int DATA_W = 36;
  localparam int DEPTH = 2048;
  localparam int PTR_W = 12;
  localparam int CNT_W = 13;
  localparam int OFF_W = 11;
  localparam int STAGE_DEPTH = 16;
  localparam int STAGE_CW = 5;
  localparam int PROG_BITS = 2 * OFF_W;
  localparam logic [OFF_W-1:0] OFF_PRESET = 11'h008;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 13'h0800;
  localparam logic [PTR_W-1:0] PTR_ONE = 12'h001;
  localparam logic [1:0] PAST_NEED = 2'h2;
  localparam logic [4:0] PROG_LAST = 5'h15;

  // Write-side pins and offset programming controls
  typedef struct packed {
    logic clk;
    logic cs_n;
    logic wsel;
    logic strobe;
    logic mbsel;
    logic prog_enable;
    logic prog_from_port;
    logic ser_en;
    logic ser_bit;
    logic [DATA_W-1:0] data;
  } dcfrm_a_pins_t;

  // Read-side pins and replay controls
  typedef struct packed {
    logic clk;
    logic cs_n;
    logic rsel;
    logic strobe;
    logic mbsel;
    logic replay;
    logic restart;
    logic [DATA_W-1:0] data;
  } dcfrm_b_pins_t;
endpackage : dcfrm_pkg
`default_nettype wire

// [src/dcfrm_top.sv]
// Dual-port replay FIFO with almost flags, staging buffer and mailboxes
// Function
// - low_fill_flag low at or below low offset, high above it.
// - low_fill_flag rises on second read-side edge after the filling write.
// - Offsets preset at reset, else loaded from write port or serially.
// - high_fill_flag low when count reaches depth minus high offset.
// - high_fill_flag rises on second write-side edge after the draining read.
// - A word in the output register counts as removed.
// - Almost flags pass two destination-edge synchroniser stages.
// - Replay entered on read edge with replay input and valid data.
// - Replay left on read edge with replay input low.
// - Restart after two reads past mark reloads the first replay word.
// - Current pointer feeds valid and low flag; shadow feeds space and high.
// - Writes continue in replay; high and space flags count from mark.
// - Restart copies shadow to current; valid updates at once.
// - Leaving replay swaps pointers for space and high flags via sync.
// - Write-side mailbox write stores write data into mailbox_to_b.
// - Read-side mailbox write stores read data into mailbox_to_a.
// - Mailbox write drops its full flag; writes ignored while low.
// - Read side shows FIFO or mailbox_to_b; write side shows mailbox_to_a.
// - Mailbox reads raise the matching full flag on their side clock.
// - Mailbox contents change only on a new write.
// - Writes ignored during serial programming until space flag rises.
// - FIFO write needs select, direction, strobe and space flag.
// - FIFO read needs select, direction, strobe and valid flag.
// - Writes ignored while full.
// - Reads ignored and output held while no valid data.
`default_nettype none

// Staging buffer in front of the main memory
module dcfrm_stage_fifo #(
  parameter int W = 36,
  parameter int D = 16,
  parameter int AW = $clog2(D),
  parameter int CW = $clog2(D + 1)
) (
  input wire logic ref_clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [W-1:0] in_data, // Incoming word
  output logic out_valid, // Word available
  input wire logic out_ready, // Consumer takes word
  output logic [W-1:0] out_data, // Oldest word
  output logic [CW-1:0] count // Words held
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wa_q;
  logic [AW-1:0] ra_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready = (cnt_q != CW'(D));
  assign out_valid = (cnt_q != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[ra_q];
  assign count = cnt_q;

  // Storage
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wa_q] <= in_data;
  end

  // Addresses and occupancy
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wa_q <= '0;
      ra_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wa_q <= (wa_q == AW'(D - 1)) ? '0 : wa_q + AW'(1);
      if (pop)
        ra_q <= (ra_q == AW'(D - 1)) ? '0 : ra_q + AW'(1);
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
endmodule : dcfrm_stage_fifo

// Top level of the block
module dcfrm_top #(
  parameter int DEPTH = dcfrm_pkg::DEPTH,
  parameter logic [dcfrm_pkg::OFF_W-1:0] OFF_PRESET = dcfrm_pkg::OFF_PRESET
) (
  input wire logic ref_clk, // System clock, 40 MHz
  input wire logic rst, // Async reset, high
  input wire dcfrm_pkg::dcfrm_a_pins_t a_pins, // Write-side pins
  input wire dcfrm_pkg::dcfrm_b_pins_t b_pins, // Read-side pins
  output logic [dcfrm_pkg::DATA_W-1:0] a_side_data_out, // Write-side data out
  output logic a_side_data_oe_n, // Low while write side drives
  output logic [dcfrm_pkg::DATA_W-1:0] b_side_data_out, // Read-side data out
  output logic b_side_data_oe_n, // Low while read side drives
  output logic space_free_flag, // Room to write
  output logic data_valid_flag, // Output register holds new word
  output logic low_fill_flag, // Active-low almost empty
  output logic high_fill_flag, // Active-low almost full
  output logic mail_one_full_n, // mailbox_to_b holds mail, low
  output logic mail_two_full_n, // mailbox_to_a holds mail, low
  output logic replay_active // Replay mode state
);
  localparam int DW = dcfrm_pkg::DATA_W;
  localparam int PW = dcfrm_pkg::PTR_W;
  localparam int CW = dcfrm_pkg::CNT_W;
  localparam int OW = dcfrm_pkg::OFF_W;
  localparam int AW = $clog2(DEPTH);

  dcfrm_pkg::dcfrm_a_pins_t a_s1_q, a_s2_q;
  dcfrm_pkg::dcfrm_b_pins_t b_s1_q, b_s2_q;
  logic wclk_d_q, rclk_d_q;
  logic w_edge, r_edge;
  logic [DW-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q, shadow_ptr_q;
  logic [DW-1:0] out_q, mailbox_to_b, mailbox_to_a;
  logic [OW-1:0] low_off_q, high_off_q;
  logic [dcfrm_pkg::PROG_BITS-1:0] shift_q;
  logic [4:0] prog_cnt_q;
  logic prog_done_q, init_q;
  logic replay_q;
  logic [1:0] past_q;
  logic sf_s1_q, sf_q, av_s1_q, av_s2_q, lf_s1_q, lf_q, hf_s1_q, hf_q;
  logic dv_q, m1_q, m2_q;
  logic a_wr_try, a_fifo_wr, a_mail_wr, a_mail_rd;
  logic b_fifo_rd, b_mail_rd, b_mail_wr, b_restart;
  logic st_ready, st_valid, st_pop;
  logic [DW-1:0] st_data;
  logic [dcfrm_pkg::STAGE_CW-1:0] st_count;
  logic [PW-1:0] base_ptr;
  logic [PW-1:0] base_diff, rd_diff;
  logic [CW-1:0] total_cnt, rd_cnt;
  logic free_cond, av_cond, lf_cond, hf_cond, main_room;

  // Port access decode shared by both sides
  function automatic logic port_go(input logic cs_n, input logic dir, input logic strobe);
    port_go = ~cs_n & dir & strobe;
  endfunction : port_go

  // Pin synchronisers and clock history, unreset so pins are real at release
  always_ff @(posedge ref_clk)
  begin
    a_s1_q <= a_pins;
    a_s2_q <= a_s1_q;
    b_s1_q <= b_pins;
    b_s2_q <= b_s1_q;
    wclk_d_q <= a_s2_q.clk;
    rclk_d_q <= b_s2_q.clk;
  end

  // Side clock edges and port operations
  assign w_edge = a_s2_q.clk & ~wclk_d_q;
  assign r_edge = b_s2_q.clk & ~rclk_d_q;
  assign a_wr_try = w_edge & port_go(a_s2_q.cs_n, a_s2_q.wsel, a_s2_q.strobe) & ~a_s2_q.mbsel;
  assign a_fifo_wr = a_wr_try & sf_q & st_ready & prog_done_q;
  assign a_mail_wr = w_edge & port_go(a_s2_q.cs_n, a_s2_q.wsel, a_s2_q.strobe) & a_s2_q.mbsel;
  assign a_mail_rd = w_edge & port_go(a_s2_q.cs_n, ~a_s2_q.wsel, a_s2_q.strobe) & a_s2_q.mbsel;
  assign b_fifo_rd = r_edge & port_go(b_s2_q.cs_n, b_s2_q.rsel, b_s2_q.strobe)
    & ~b_s2_q.mbsel & dv_q;
  assign b_mail_rd = r_edge & port_go(b_s2_q.cs_n, b_s2_q.rsel, b_s2_q.strobe) & b_s2_q.mbsel;
  assign b_mail_wr = r_edge & port_go(b_s2_q.cs_n, ~b_s2_q.rsel, b_s2_q.strobe) & b_s2_q.mbsel;
  assign b_restart = r_edge & replay_q & b_s2_q.replay & b_s2_q.restart
    & (past_q == dcfrm_pkg::PAST_NEED);

  // Fill levels: output register word already removed, shadow in replay
  assign base_ptr = replay_q ? shadow_ptr_q : rd_ptr_q;
  assign base_diff = wr_ptr_q - base_ptr;
  assign rd_diff = wr_ptr_q - rd_ptr_q;
  assign total_cnt = CW'(base_diff) + CW'(st_count);
  assign rd_cnt = CW'(rd_diff);
  assign main_room = (CW'(base_diff) < CW'(DEPTH));
  assign free_cond = prog_done_q & (total_cnt < CW'(DEPTH));
  assign av_cond = (wr_ptr_q != rd_ptr_q);
  assign lf_cond = (rd_cnt > CW'(low_off_q));
  assign hf_cond = (total_cnt < (CW'(DEPTH) - CW'(high_off_q)));
  assign st_pop = st_valid & main_room;

  // Write-side staging buffer, stalled when main memory is full
  dcfrm_stage_fifo #(
    .W(DW),
    .D(dcfrm_pkg::STAGE_DEPTH),
    .CW(dcfrm_pkg::STAGE_CW)
  ) u_stage (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(a_fifo_wr),
    .in_ready(st_ready),
    .in_data(a_s2_q.data),
    .out_valid(st_valid),
    .out_ready(main_room),
    .out_data(st_data),
    .count(st_count)
  );

  // Main memory write
  always_ff @(posedge ref_clk)
  begin
    if (st_pop)
      mem[wr_ptr_q[AW-1:0]] <= st_data;
  end

  // Write pointer
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      wr_ptr_q <= '0;
    else if (st_pop)
      wr_ptr_q <= wr_ptr_q + dcfrm_pkg::PTR_ONE;
  end

  // Offset presets, port loading and serial shifting
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      low_off_q <= OFF_PRESET;
      high_off_q <= OFF_PRESET;
      shift_q <= '0;
      prog_cnt_q <= '0;
      prog_done_q <= 1'b0;
      init_q <= 1'b0;
    end
    else
    begin
      init_q <= 1'b1;
      if (!init_q)
        prog_done_q <= ~a_s2_q.prog_enable;
      else if (!prog_done_q && a_s2_q.prog_from_port && a_wr_try)
      begin
        // Port load: first write sets low offset, second sets high offset
        if (prog_cnt_q == '0)
          low_off_q <= a_s2_q.data[OW-1:0];
        else
        begin
          high_off_q <= a_s2_q.data[OW-1:0];
          prog_done_q <= 1'b1;
        end
        prog_cnt_q <= prog_cnt_q + 5'h01;
      end
      else if (!prog_done_q && !a_s2_q.prog_from_port && w_edge && a_s2_q.ser_en)
      begin
        // Serial load, bits need not be consecutive
        shift_q <= {shift_q[dcfrm_pkg::PROG_BITS-2:0], a_s2_q.ser_bit};
        prog_cnt_q <= prog_cnt_q + 5'h01;
        if (prog_cnt_q == dcfrm_pkg::PROG_LAST)
        begin
          low_off_q <= shift_q[dcfrm_pkg::PROG_BITS-2:OW-1];
          high_off_q <= {shift_q[OW-2:0], a_s2_q.ser_bit};
          prog_done_q <= 1'b1;
        end
      end
    end
  end

  // Write-side flags: fall at once, rise after two write-side edges
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sf_s1_q <= 1'b0;
      sf_q <= 1'b0;
      hf_s1_q <= 1'b1;
      hf_q <= 1'b1;
    end
    else
    begin
      if (!free_cond)
      begin
        sf_s1_q <= 1'b0;
        sf_q <= 1'b0;
      end
      else if (w_edge)
      begin
        sf_s1_q <= 1'b1;
        sf_q <= sf_s1_q;
      end
      if (!hf_cond)
      begin
        hf_s1_q <= 1'b0;
        hf_q <= 1'b0;
      end
      else if (w_edge)
      begin
        hf_s1_q <= 1'b1;
        hf_q <= hf_s1_q;
      end
    end
  end

  // Read-side flags: fall at once, rise after two read-side edges
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      av_s1_q <= 1'b0;
      av_s2_q <= 1'b0;
      lf_s1_q <= 1'b0;
      lf_q <= 1'b0;
    end
    else
    begin
      if (!av_cond)
      begin
        av_s1_q <= 1'b0;
        av_s2_q <= 1'b0;
      end
      else if (r_edge)
      begin
        av_s1_q <= 1'b1;
        av_s2_q <= av_s1_q;
      end
      if (!lf_cond)
      begin
        lf_s1_q <= 1'b0;
        lf_q <= 1'b0;
      end
      else if (r_edge)
      begin
        lf_s1_q <= 1'b1;
        lf_q <= lf_s1_q;
      end
    end
  end

  // Replay mode, shadow pointer and reads past the mark
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      replay_q <= 1'b0;
      shadow_ptr_q <= '0;
      past_q <= '0;
    end
    else if (r_edge)
    begin
      if (!b_s2_q.replay)
        replay_q <= 1'b0;
      else if (!replay_q && dv_q)
      begin
        replay_q <= 1'b1;
        shadow_ptr_q <= rd_ptr_q - dcfrm_pkg::PTR_ONE;
        past_q <= '0;
      end
      else if (b_restart)
        past_q <= '0;
      else if (b_fifo_rd && av_cond && past_q != dcfrm_pkg::PAST_NEED)
        past_q <= past_q + 2'h1;
    end
  end

  // Current read pointer, output register and valid flag
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_ptr_q <= '0;
      out_q <= '0;
      dv_q <= 1'b0;
    end
    else if (b_restart)
    begin
      out_q <= mem[shadow_ptr_q[AW-1:0]];
      rd_ptr_q <= shadow_ptr_q + dcfrm_pkg::PTR_ONE;
      dv_q <= 1'b1;
    end
    else if (r_edge && (!dv_q || b_fifo_rd) && av_s2_q && av_cond)
    begin
      out_q <= mem[rd_ptr_q[AW-1:0]];
      rd_ptr_q <= rd_ptr_q + dcfrm_pkg::PTR_ONE;
      dv_q <= 1'b1;
    end
    else if (b_fifo_rd)
      dv_q <= 1'b0;
  end

  // Mailbox toward the read side; a write beats a same-cycle read
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mailbox_to_b <= '0;
      m1_q <= 1'b1;
    end
    else if (a_mail_wr && m1_q)
    begin
      mailbox_to_b <= a_s2_q.data;
      m1_q <= 1'b0;
    end
    else if (b_mail_rd)
      m1_q <= 1'b1;
  end

  // Mailbox toward the write side; a write beats a same-cycle read
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      mailbox_to_a <= '0;
      m2_q <= 1'b1;
    end
    else if (b_mail_wr && m2_q)
    begin
      mailbox_to_a <= b_s2_q.data;
      m2_q <= 1'b0;
    end
    else if (a_mail_rd)
      m2_q <= 1'b1;
  end

  // Registered data outputs
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      a_side_data_out <= '0;
      b_side_data_out <= '0;
    end
    else
    begin
      a_side_data_out <= mailbox_to_a;
      b_side_data_out <= b_s2_q.mbsel ? mailbox_to_b : out_q;
    end
  end

  // Output enables and flag outputs
  assign a_side_data_oe_n = a_s2_q.cs_n | a_s2_q.wsel;
  assign b_side_data_oe_n = b_s2_q.cs_n | ~b_s2_q.rsel;
  assign space_free_flag = sf_q;
  assign data_valid_flag = dv_q;
  assign low_fill_flag = lf_q;
  assign high_fill_flag = hf_q;
  assign mail_one_full_n = m1_q;
  assign mail_two_full_n = m2_q;
  assign replay_active = replay_q;
endmodule : dcfrm_top
`default_nettype wire

// [verif/dcfrm_assertions.sv]
// Port-level assertions for the replay FIFO with mailboxes
`default_nettype none
module dcfrm_checker #(
  parameter int DEPTH = 2048
) (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire dcfrm_pkg::dcfrm_a_pins_t a_pins, // Write side
  input wire dcfrm_pkg::dcfrm_b_pins_t b_pins, // Read side
  input wire logic [dcfrm_pkg::DATA_W-1:0] a_side_data_out, // A data
  input wire logic a_side_data_oe_n, // A enable
  input wire logic [dcfrm_pkg::DATA_W-1:0] b_side_data_out, // B data
  input wire logic b_side_data_oe_n, // B enable
  input wire logic space_free_flag, // Room
  input wire logic data_valid_flag, // Valid
  input wire logic low_fill_flag, // Almost empty
  input wire logic high_fill_flag, // Almost full
  input wire logic mail_one_full_n, // Mail to B
  input wire logic mail_two_full_n, // Mail to A
  input wire logic replay_active // Replay
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] age_q;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Cycles since reset, saturating
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      age_q <= 2'h0;
    else if (age_q != 2'h3)
      age_q <= age_q + 2'h1;
  end
  sequence s_out_idle;
    (!data_valid_flag && !b_pins.mbsel) [*5];
  endsequence
  sequence s_mail_held;
    (!mail_two_full_n) [*2];
  endsequence
  property p_reset_levels;
    $fell(rst) |-> mail_one_full_n && mail_two_full_n && !replay_active
      && !data_valid_flag && !low_fill_flag && high_fill_flag;
  endproperty
  property p_full_high;
    $fell(space_free_flag) |-> !high_fill_flag;
  endproperty
  property p_low_valid;
    low_fill_flag |-> data_valid_flag;
  endproperty
  property p_replay_entry;
    $rose(replay_active) |-> $past(data_valid_flag);
  endproperty
  property p_mail_hold;
    s_mail_held |=> $stable(a_side_data_out);
  endproperty
  property p_out_hold;
    s_out_idle |-> $stable(b_side_data_out);
  endproperty
  property p_oe_a;
    age_q == 2'h3 |-> a_side_data_oe_n == $past(a_pins.cs_n | a_pins.wsel, 2);
  endproperty
  property p_oe_b;
    age_q == 2'h3 |-> b_side_data_oe_n == $past(b_pins.cs_n | !b_pins.rsel, 2);
  endproperty
  a_reset_levels: assert property (p_reset_levels) else $error("bad reset levels");
  a_full_high: assert property (p_full_high) else $error("full without high flag");
  a_low_valid: assert property (p_low_valid) else $error("low flag without data");
  a_replay_entry: assert property (p_replay_entry) else $error("replay without data");
  a_mail_hold: assert property (p_mail_hold) else $error("mailbox changed");
  a_out_hold: assert property (p_out_hold) else $error("output not held");
  a_oe_a: assert property (p_oe_a) else $error("write side enable wrong");
  a_oe_b: assert property (p_oe_b) else $error("read side enable wrong");
endmodule : dcfrm_checker
bind dcfrm_top dcfrm_checker #(.DEPTH(DEPTH)) u_checker (.ref_clk(ref_clk), .rst(rst),
  .a_pins(a_pins), .b_pins(b_pins), .a_side_data_out(a_side_data_out),
  .a_side_data_oe_n(a_side_data_oe_n), .b_side_data_out(b_side_data_out),
  .b_side_data_oe_n(b_side_data_oe_n), .space_free_flag(space_free_flag),
  .data_valid_flag(data_valid_flag), .low_fill_flag(low_fill_flag),
  .high_fill_flag(high_fill_flag), .mail_one_full_n(mail_one_full_n),
  .mail_two_full_n(mail_two_full_n), .replay_active(replay_active));
`default_nettype wire

// [verif/dcfrm_port_clocks.sv]
// Free-running port clocks of the two bus controllers
`default_nettype none
module dcfrm_port_clocks #(
  parameter int HALF_A = 5,
  parameter int HALF_B = 6
) (
  input wire logic ref_clk, // Clock
  output logic write_side_clock, // Writer clock
  output logic read_side_clock // Reader clock
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_a = 0;
  int cnt_b = 0;
  initial
  begin
    write_side_clock = 1'b0;
    read_side_clock = 1'b0;
  end
  // Toggle each clock every half period, at least two cycles per phase
  always @(posedge ref_clk)
  begin
    cnt_a <= (cnt_a == HALF_A - 1) ? 0 : cnt_a + 1;
    cnt_b <= (cnt_b == HALF_B - 1) ? 0 : cnt_b + 1;
    if (cnt_a == HALF_A - 1)
      write_side_clock <= ~write_side_clock;
    if (cnt_b == HALF_B - 1)
      read_side_clock <= ~read_side_clock;
  end
endmodule : dcfrm_port_clocks
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the replay FIFO with mailboxes
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 32;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  wire logic wclk;
  wire logic rclk;
  dcfrm_pkg::dcfrm_a_pins_t a_r, a_in;
  dcfrm_pkg::dcfrm_b_pins_t b_r, b_in;
  logic [dcfrm_pkg::DATA_W-1:0] a_out, b_out, mark, h1;
  logic a_oe_n, b_oe_n, space_free, data_valid, low_fill, high_fill, mb_b_n, mb_a_n;
  logic replay_on, took;
  logic [36:0] notes[$];
  logic [36:0] nt;
  logic [dcfrm_pkg::DATA_W-1:0] m[$];
  logic [31:0] seed = 32'hA72A7D15;
  int mismatches = 0;
  int n_compared = 0;
  event chk_ev;
  always #12.5 ref_clk = ~ref_clk;
  // Port clocks join the level pins
  always_comb
  begin
    a_in = a_r;
    a_in.clk = wclk;
    b_in = b_r;
    b_in.clk = rclk;
  end
  dcfrm_port_clocks u_clocks (.ref_clk(ref_clk), .write_side_clock(wclk),
    .read_side_clock(rclk));
  dcfrm_top #(.DEPTH(DEPTH), .OFF_PRESET(11'h008)) DUT (.ref_clk(ref_clk), .rst(rst),
    .a_pins(a_in), .b_pins(b_in), .a_side_data_out(a_out), .a_side_data_oe_n(a_oe_n),
    .b_side_data_out(b_out), .b_side_data_oe_n(b_oe_n), .space_free_flag(space_free),
    .data_valid_flag(data_valid), .low_fill_flag(low_fill), .high_fill_flag(high_fill),
    .mail_one_full_n(mb_b_n), .mail_two_full_n(mb_a_n), .replay_active(replay_on));
  function automatic logic [35:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return {seed[3:0], seed};
  endfunction : rnd
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic note(input logic sel, input logic [35:0] v);
    notes.push_back({sel, v});
    #1;
    ->chk_ev;
  endtask : note
  task automatic end_of_test();
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  // Write-side cycle; took tells whether room was shown
  task automatic a_op(input logic wr, input logic mb, input logic [35:0] d);
    @(negedge wclk);
    repeat (2) @(posedge ref_clk);
    #1;
    took = space_free;
    @(posedge ref_clk);
    a_r.cs_n <= 1'b0;
    a_r.wsel <= wr;
    a_r.strobe <= 1'b1;
    a_r.mbsel <= mb;
    a_r.data <= d;
    @(negedge wclk);
    a_r.cs_n <= 1'b1;
    a_r.strobe <= 1'b0;
    a_r.data <= ~d;
  endtask : a_op
  // Read-side cycle; replay level persists afterwards
  task automatic b_op(input logic en, input logic rd, input logic mb, input logic rs,
    input logic rp, input logic [35:0] d);
    @(negedge rclk);
    @(posedge ref_clk);
    b_r.cs_n <= ~en;
    b_r.rsel <= rd;
    b_r.strobe <= en;
    b_r.mbsel <= mb;
    b_r.restart <= rs;
    b_r.replay <= rp;
    b_r.data <= d;
    @(negedge rclk);
    b_r.cs_n <= 1'b1;
    b_r.strobe <= 1'b0;
    b_r.restart <= 1'b0;
    b_r.data <= ~d;
  endtask : b_op
  // Compare each noted result with the selected data output
  initial
  begin
    forever
    begin
      @(chk_ev);
      nt = notes.pop_front();
      check(nt[36] ? a_out : b_out, nt[35:0]);
    end
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    a_r = '0;
    a_r.cs_n = 1'b1;
    b_r = '0;
    b_r.cs_n = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 200 && space_free !== 1'b1; i++) @(posedge ref_clk);
    check(space_free, 1'b1);
    mark = rnd();
    h1 = rnd();
    a_op(1'b1, 1'b1, mark);
    check(mb_b_n, 1'b0);
    a_op(1'b1, 1'b1, h1);
    b_op(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, '0);
    note(1'b0, mark);
    check(mb_b_n, 1'b1);
    b_op(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, '0);
    note(1'b0, mark);
    b_op(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, h1);
    check(mb_a_n, 1'b0);
    note(1'b1, h1);
    a_op(1'b0, 1'b1, '0);
    check(mb_a_n, 1'b1);
    for (int i = 0; i < DEPTH + 6; i++)
    begin
      h1 = rnd();
      a_op(1'b1, 1'b0, h1);
      if (took === 1'b1)
        m.push_back(h1);
      if (i == 8 || i == 9)
      begin
        repeat (80) @(posedge ref_clk);
        #1;
        check(low_fill, i == 9);
      end
    end
    // Read side back to the FIFO output register
    b_r.mbsel <= 1'b0;
    repeat (40) @(posedge ref_clk);
    #1;
    check(space_free, 1'b0);
    check(high_fill, 1'b0);
    check(m.size(), DEPTH + 1);
    note(1'b0, m[0]);
    // One read first, so the marked word's location is not reused
    b_op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, '0);
    void'(m.pop_front());
    note(1'b0, m[0]);
    mark = m[0];
    h1 = m[1];
    b_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, '0);
    check(replay_on, 1'b1);
    repeat (2)
    begin
      b_op(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, '0);
      void'(m.pop_front());
      note(1'b0, m[0]);
    end
    b_op(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, '0);
    m.push_front(h1);
    m.push_front(mark);
    note(1'b0, mark);
    check(data_valid, 1'b1);
    check(space_free, 1'b0);
    b_op(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, '0);
    check(replay_on, 1'b0);
    repeat (60) @(posedge ref_clk);
    #1;
    check(space_free, 1'b1);
    while (m.size() > 1)
    begin
      b_op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, '0);
      void'(m.pop_front());
      note(1'b0, m[0]);
    end
    check(high_fill, 1'b1);
    repeat (2)
    begin
      b_op(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, '0);
      note(1'b0, m[0]);
    end
    check(data_valid, 1'b0);
    // Let the compare process take the last note
    repeat (2) @(posedge ref_clk);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
